// ==== rtl/serial_rx_channel.sv ====
/*
  Receive side of one asynchronous serial channel with register port.
  Assumes a processor on the register port and a remote transmitter on
  the data line; pins and the bit clock are asynchronous and synchronised.
*/
// The implementer's own choices: the placing of the registers and the plain strobed port.
// Functional notes
// - Reception starts only with enable set, and carrier low under auto enables.
// - Start bit valid after half a bit low; then sample mid-bit.
// - In x1 mode sample on rising bit clock; sync comes from outside.
// - Short characters keep parity above data and fill with ones.
// - Three data stages and three matching error stages loaded together.
// - Parity error set on mismatch, held until error reset.
// - Framing error set on low stop bit, per character only.
// - Framing error adds half a bit in x16 mode, one bit clock in x1 mode, before hunting for a start.
// - Fourth unread character overwrites third entry, flagged overrun until reset.
// - Framing and overrun raise a special receive interrupt vector.
// - Break start and end each raise an external status interrupt.
// - Carrier inactive beyond minimum width raises interrupt; status holds inverse.
// - First-character-only mode holds data and error until error reset.
// - Every-character mode returns a different vector on error.
// - Character-available bit shows buffered data, clears once buffers read.
// - Transmit buffer empty bit reads one when no character held.
// - All-sent bit shows all transmission completed.
// - Synchronous modes sample receive on rising bit clock edge.
`timescale 1ns/1ps
module serial_rx_channel
  import serial_rx_pkg::*;
#(
  parameter int DEPTH = 3
)(
  // Clock, reset, enable
  input  wire logic       CORE_CLK_I,
  input  wire logic       RESET_I,
  input  wire logic       CLK_EN_I,
  // Register port
  input  wire logic [2:0] ADDR_I,
  input  wire logic [11:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  // Serial pins
  input  wire logic       RX_DATA_I,
  input  wire logic       RECEIVE_BIT_CLOCK_I,
  input  wire logic       CARRIER_DETECT_IN_N_I,
  // Interrupt request
  output logic            INT_O
);

  typedef enum {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP, ST_FRAME_WAIT} rx_state_t;

  rx_state_t   state_reg;
  logic [11:0] cfg_reg;
  logic [7:0]  vector_reg;
  logic [2:0]  rxd_sync, clk_sync, dcd_sync;
  logic [4:0]  tick_cnt_reg;
  logic [2:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic        par_acc_reg;
  logic        par_err_frame_reg;
  rx_entry_t   fifo_reg [DEPTH];
  logic [1:0]  count_reg;
  logic        par_sticky_reg, ovr_sticky_reg;
  logic        hold_reg;
  logic        break_reg, ext_pend_reg, carrier_state_reg;
  logic [7:0]  carrier_cnt_reg;
  logic        special_pend_reg;
  logic [7:0]  rdata_next;
  logic        bit_tick, rx_in, clk_rise, carrier_low, rx_allowed;
  logic        frame_done, good_stop, cmd_wr, err_reset, ext_reset, pop;
  logic [2:0]  len_m1;
  rx_entry_t   new_entry;

  // Two flip-flop synchronisers, third stage for edge detection
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I)
    begin
      rxd_sync <= 3'h7;
      clk_sync <= 3'h0;
      dcd_sync <= 3'h7;
    end
    else if (CLK_EN_I)
    begin
      rxd_sync <= {rxd_sync[1:0], RX_DATA_I};
      clk_sync <= {clk_sync[1:0], RECEIVE_BIT_CLOCK_I};
      dcd_sync <= {dcd_sync[1:0], CARRIER_DETECT_IN_N_I};
    end
  end

  // Decoded helpers
  assign rx_in       = rxd_sync[1];
  assign clk_rise    = clk_sync[1] & ~clk_sync[2];
  assign carrier_low = ~dcd_sync[1];
  assign rx_allowed  = cfg_reg[CFG_RX_ENABLE] &
                       (~cfg_reg[CFG_AUTO_ENABLE] | carrier_low);
  assign bit_tick    = clk_rise & ((cfg_reg[CFG_X1_MODE]) ? 1'b1 :
                                   (tick_cnt_reg == OVERSAMPLE - 5'h1));
  assign len_m1      = {1'b1, cfg_reg[CFG_LEN_LO+1:CFG_LEN_LO]};
  assign cmd_wr      = WR_I & (ADDR_I == ADDR_COMMAND);
  assign err_reset   = cmd_wr & (WDATA_I[2:0] == CMD_ERROR_RESET);
  assign ext_reset   = cmd_wr & (WDATA_I[2:0] == CMD_EXT_RESET);
  assign pop         = RD_I & (ADDR_I == ADDR_DATA) & (count_reg != 2'h0) & ~hold_reg;
  assign good_stop   = rx_in;
  assign frame_done  = (state_reg == ST_STOP) & bit_tick;

  // Fill short characters with ones above data and parity
  function automatic logic [7:0] assemble(input logic [7:0] sh, input logic [2:0] lm1,
                                          input logic pen, input logic pb);
    logic [7:0] r;
    int         n;
    r = 8'hFF;
    n = int'(lm1) + 1;
    for (int i = 0; i < 8; i++)
      if (i < n) r[i] = sh[i + 8 - n];
    if (pen && n < 8) r[n] = pb;
    return r;
  endfunction

  assign new_entry.data    = assemble(shift_reg, len_m1,
                                      cfg_reg[CFG_PARITY_EN], par_acc_reg);
  assign new_entry.framing = ~good_stop;
  assign new_entry.parity  = par_err_frame_reg;
  assign new_entry.overrun = 1'b0;

  // Receive configuration; while a character is in flight only bits 11:8 are written, bits 7:0 stay frozen
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I)
      cfg_reg <= CFG_RESET;
    else if (CLK_EN_I && WR_I && ADDR_I == ADDR_CONFIG && state_reg == ST_IDLE)
      cfg_reg <= WDATA_I;
    else if (CLK_EN_I && WR_I && ADDR_I == ADDR_CONFIG)
      cfg_reg[CFG_RX_INT_EN:CFG_EXT_INT_EN] <= WDATA_I[CFG_RX_INT_EN:CFG_EXT_INT_EN];
  end

  // Base interrupt vector
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I)
      vector_reg <= VECTOR_RESET;
    else if (CLK_EN_I && WR_I && ADDR_I == ADDR_VECTOR)
      vector_reg <= WDATA_I[7:0];
  end

  // Receive state machine with start validation and mid-bit sampling
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I)
    begin
      state_reg         <= ST_IDLE;
      tick_cnt_reg      <= 5'h0;
      bit_cnt_reg       <= 3'h0;
      shift_reg         <= 8'h00;
      par_acc_reg       <= 1'b0;
      par_err_frame_reg <= 1'b0;
    end
    else if (CLK_EN_I && clk_rise)
    begin
      tick_cnt_reg <= (bit_tick) ? 5'h0 : tick_cnt_reg + 5'h1;
      unique case (state_reg)
        ST_IDLE:
          if (rx_allowed && !rx_in && !hold_reg)
          begin
            // In x1 the edge that finds the start is its sample; next edge is bit 0
            state_reg    <= (cfg_reg[CFG_X1_MODE]) ? ST_DATA : ST_START;
            tick_cnt_reg <= 5'h0;
            bit_cnt_reg  <= 3'h0;
            par_acc_reg  <= ~cfg_reg[CFG_PARITY_EVEN];
          end
        ST_START:
          if (rx_in)
            state_reg <= ST_IDLE;    // Glitch rejected
          else if (tick_cnt_reg == (OVERSAMPLE >> 1) - 5'h1)
          begin
            state_reg    <= ST_DATA;
            tick_cnt_reg <= 5'h0;
          end
        ST_DATA:
          if (bit_tick)
          begin
            shift_reg   <= {rx_in, shift_reg[7:1]};
            par_acc_reg <= par_acc_reg ^ rx_in;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == len_m1)
              state_reg <= (cfg_reg[CFG_PARITY_EN]) ? ST_PARITY : ST_STOP;
          end
        ST_PARITY:
          if (bit_tick)
          begin
            par_err_frame_reg <= par_acc_reg ^ rx_in;
            par_acc_reg       <= rx_in;
            state_reg         <= ST_STOP;
          end
        ST_STOP:
          if (bit_tick)
          begin
            state_reg         <= (good_stop) ? ST_IDLE : ST_FRAME_WAIT;
            tick_cnt_reg      <= 5'h0;
            par_err_frame_reg <= 1'b0;
          end
        ST_FRAME_WAIT:
          if (cfg_reg[CFG_X1_MODE] || tick_cnt_reg == (OVERSAMPLE >> 1) - 5'h1)
            state_reg <= ST_IDLE;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // Three-stage data and error buffer; overflow overwrites the last entry
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I)
    begin
      count_reg <= 2'h0;
      for (int i = 0; i < DEPTH; i++)
        fifo_reg[i] <= '0;
    end
    else if (CLK_EN_I)
    begin
      if (pop)
      begin
        for (int i = 0; i < DEPTH - 1; i++)
          fifo_reg[i] <= fifo_reg[i + 1];
      end
      if (frame_done && !(pop && count_reg == 2'h0))
      begin
        if (count_reg == 2'(DEPTH) && !pop)
        begin
          fifo_reg[DEPTH-1]         <= new_entry;
          fifo_reg[DEPTH-1].overrun <= 1'b1;
        end
        else
          fifo_reg[count_reg - 2'(pop)] <= new_entry;
      end
      if (frame_done && !pop && count_reg != 2'(DEPTH))
        count_reg <= count_reg + 2'h1;
      else if (pop && !frame_done)
        count_reg <= count_reg - 2'h1;
    end
  end

  // Sticky parity and overrun; set wins over error reset
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I)
    begin
      par_sticky_reg <= 1'b0;
      ovr_sticky_reg <= 1'b0;
    end
    else if (CLK_EN_I)
    begin
      if (frame_done && par_err_frame_reg)
        par_sticky_reg <= 1'b1;
      else if (err_reset)
        par_sticky_reg <= 1'b0;
      if (pop && fifo_reg[0].overrun)
        ovr_sticky_reg <= 1'b1;  // Latches as the flagged entry is read
      else if (err_reset)
        ovr_sticky_reg <= 1'b0;
    end
  end

  // Hold in first-character-only mode; set on arrival so error reset releases it
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I)
      hold_reg <= 1'b0;
    else if (CLK_EN_I)
    begin
      if (cfg_reg[CFG_FIRST_ONLY] && frame_done &&
          (!good_stop || par_err_frame_reg || (count_reg == 2'(DEPTH) && !pop)))
        hold_reg <= 1'b1;
      else if (err_reset)
        hold_reg <= 1'b0;
    end
  end

  // Break and carrier detection, external status pending latch
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I)
    begin
      break_reg         <= 1'b0;
      ext_pend_reg      <= 1'b0;
      carrier_state_reg <= 1'b0;
      carrier_cnt_reg   <= 8'h00;
    end
    else if (CLK_EN_I)
    begin
      if (frame_done && !good_stop && shift_reg == 8'h00 && !break_reg)
      begin
        break_reg    <= 1'b1;
        ext_pend_reg <= cfg_reg[CFG_EXT_INT_EN];
      end
      else if (break_reg && rx_in && state_reg == ST_IDLE)
      begin
        break_reg    <= 1'b0;
        ext_pend_reg <= cfg_reg[CFG_EXT_INT_EN];
      end
      else if (carrier_cnt_reg == 8'(CARRIER_CYCLES) &&
               carrier_state_reg != dcd_sync[1])
      begin
        carrier_state_reg <= dcd_sync[1];
        ext_pend_reg      <= cfg_reg[CFG_EXT_INT_EN];
      end
      else if (ext_reset)
        ext_pend_reg <= 1'b0;
      carrier_cnt_reg <= (dcd_sync[1] == carrier_state_reg) ? 8'h00 :
                         (carrier_cnt_reg == 8'(CARRIER_CYCLES)) ? carrier_cnt_reg :
                         carrier_cnt_reg + 8'h1;
    end
  end

  // Special receive condition pending while data is buffered and the head entry flags framing or overrun, or sticky parity or overrun is set
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I)
      special_pend_reg <= 1'b0;
    else if (CLK_EN_I)
      special_pend_reg <= (count_reg != 2'h0) &&
                          (fifo_reg[0].framing || fifo_reg[0].overrun ||
                           par_sticky_reg || ovr_sticky_reg);
  end

  // Read mux
  always_comb
  begin
    rdata_next = 8'h00;
    unique case (ADDR_I)
      ADDR_MAIN_STATUS:
      begin
        rdata_next[MS_RX_AVAIL] = (count_reg != 2'h0);
        rdata_next[MS_TX_EMPTY] = 1'b1;
        rdata_next[MS_CARRIER]  = ~carrier_state_reg;
        rdata_next[MS_ALL_SENT] = 1'b1;
        rdata_next[MS_BREAK]    = break_reg;
      end
      ADDR_ERROR_STATUS:
      begin
        rdata_next[ES_PARITY]  = par_sticky_reg | ((count_reg != 2'h0) & fifo_reg[0].parity);
        rdata_next[ES_OVERRUN] = ovr_sticky_reg | ((count_reg != 2'h0) & fifo_reg[0].overrun);
        rdata_next[ES_FRAMING] = (count_reg != 2'h0) & fifo_reg[0].framing;
      end
      ADDR_DATA:         rdata_next = fifo_reg[0].data;
      ADDR_CONFIG:       rdata_next = cfg_reg[7:0];
      ADDR_VECTOR:       rdata_next = vector_reg;
      ADDR_MODIFIED_VEC:
        rdata_next = {vector_reg[7:4],
                      (cfg_reg[CFG_SAV]) ? (special_pend_reg ? 3'h7 :
                        (count_reg != 2'h0) ? 3'h6 : ext_pend_reg ? 3'h5 : 3'h0) :
                      vector_reg[3:1], vector_reg[0]};
      default:           rdata_next = 8'h00;
    endcase
  end

  // Registered read data and interrupt output
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I)
    begin
      RDATA_O <= 8'h00;
      INT_O   <= 1'b0;
    end
    else if (CLK_EN_I)
    begin
      RDATA_O <= (RD_I) ? rdata_next : 8'h00;
      INT_O   <= ext_pend_reg | special_pend_reg |
                 (cfg_reg[CFG_RX_INT_EN] & (count_reg != 2'h0));
    end
  end

  AST_FRAME_WAIT: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    (CLK_EN_I && frame_done && !good_stop) |=> state_reg == ST_FRAME_WAIT)
    else $error("Framing error did not add half bit");
  AST_ENABLE: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    (state_reg == ST_IDLE && !rx_allowed) |=> state_reg == ST_IDLE)
    else $error("Receive started while disabled");
  AST_AVAIL: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    (RD_I && ADDR_I == ADDR_MAIN_STATUS && CLK_EN_I) |=> RDATA_O[0] == $past(count_reg != 2'h0))
    else $error("Available bit mismatch");
  AST_PARITY_HOLD: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    (par_sticky_reg && !err_reset) |=> par_sticky_reg)
    else $error("Parity flag dropped without reset");
  AST_OVR_HOLD: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    (ovr_sticky_reg && !err_reset) |=> ovr_sticky_reg)
    else $error("Overrun flag dropped without reset");
  AST_DEPTH: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    count_reg <= 2'(DEPTH))
    else $error("Buffer count exceeded depth");
  AST_HOLD: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    (hold_reg && !err_reset) |=> hold_reg && $stable(count_reg) || !pop)
    else $error("Held character released");
  AST_CFG: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    (state_reg == ST_DATA) |=> $stable(cfg_reg[7:0]))
    else $error("Configuration changed mid character");

  COV_CHAR: cover property (@(posedge CORE_CLK_I) frame_done && good_stop);
  COV_FRAME: cover property (@(posedge CORE_CLK_I) frame_done && !good_stop);
  COV_OVR: cover property (@(posedge CORE_CLK_I) $rose(ovr_sticky_reg));
  COV_BREAK: cover property (@(posedge CORE_CLK_I) $fell(break_reg));

endmodule

// ==== rtl/serial_rx_pkg.sv ====
/*
  Shared constants and types for the asynchronous serial receive channel.
  Assumes a single core clock domain; register indices are local choices.
*/
package serial_rx_pkg;

  // Register indices on the plain register port
  localparam logic [2:0] ADDR_MAIN_STATUS   = 3'h0;
  localparam logic [2:0] ADDR_ERROR_STATUS  = 3'h1;
  localparam logic [2:0] ADDR_DATA          = 3'h2;
  localparam logic [2:0] ADDR_CONFIG        = 3'h3;
  localparam logic [2:0] ADDR_COMMAND       = 3'h4;
  localparam logic [2:0] ADDR_VECTOR        = 3'h5;
  localparam logic [2:0] ADDR_MODIFIED_VEC  = 3'h6;

  // Configuration field positions
  localparam int CFG_RX_ENABLE   = 0;
  localparam int CFG_AUTO_ENABLE = 1;
  localparam int CFG_PARITY_EN   = 2;
  localparam int CFG_PARITY_EVEN = 3;
  localparam int CFG_LEN_LO      = 4;
  localparam int CFG_STOP2       = 6;
  localparam int CFG_X1_MODE     = 7;
  localparam int CFG_EXT_INT_EN  = 8;
  localparam int CFG_SAV         = 9;
  localparam int CFG_FIRST_ONLY  = 10;
  localparam int CFG_RX_INT_EN   = 11;
  localparam logic [11:0] CFG_RESET = 12'h000;

  // Command codes
  localparam logic [2:0] CMD_EXT_RESET   = 3'h2;
  localparam logic [2:0] CMD_ERROR_RESET = 3'h6;

  // Status bit positions
  localparam int MS_RX_AVAIL  = 0;
  localparam int MS_TX_EMPTY  = 2;
  localparam int MS_CARRIER   = 3;
  localparam int MS_ALL_SENT  = 6;
  localparam int MS_BREAK     = 7;
  localparam int ES_PARITY    = 4;
  localparam int ES_OVERRUN   = 5;
  localparam int ES_FRAMING   = 6;

  // Timing: bit divider in x16 mode and carrier minimum pulse width
  localparam logic [4:0] OVERSAMPLE     = 5'h10;
  localparam int         CORE_CLK_MHZ   = 50;
  localparam int         CARRIER_MIN_NS = 200;
  localparam int         CARRIER_CYCLES = (CARRIER_MIN_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] VECTOR_RESET   = 8'h00;

  // One buffered character with its error flags
  typedef struct packed {
    logic [7:0] data;
    logic       framing;
    logic       overrun;
    logic       parity;
  } rx_entry_t;

endpackage

// ==== test/serial_tx_model.sv ====
/*
  Behavioural remote transmitter for the serial receive channel.
  Assumes the bench calls its tasks; it makes a free-running bit clock
  and drives the data line, which idles at mark (high) between frames.
*/
`timescale 1ns/1ps
module serial_tx_model #(
  parameter time HALF_PERIOD = 80
)(
  // Serial pins toward the receiver
  output logic rx_data_o,
  output logic bit_clk_o
);

  // Bit clock runs free so the x16 receiver can hunt for start bits
  initial bit_clk_o = 1'b0;
  always #HALF_PERIOD bit_clk_o = ~bit_clk_o;

  initial rx_data_o = 1'b1;

  // Holds one level for a number of bit clock periods, changing on the falling edge
  task automatic put_bit(input logic b, input int ticks);
    @(negedge bit_clk_o);
    rx_data_o = b;
    repeat (ticks - 1) @(negedge bit_clk_o);
  endtask

  // Sends one frame LSB first; x1 uses one clock per bit, else sixteen
  task automatic send(input logic [7:0] d, input int nbits, input logic pen,
                      input logic pbit, input logic stop_ok, input logic x1);
    int ticks;
    ticks = x1 ? 1 : 16;
    put_bit(1'b0, ticks);
    for (int i = 0; i < nbits; i++) put_bit(d[i], ticks);
    if (pen) put_bit(pbit, ticks);
    put_bit(stop_ok, ticks);
    put_bit(1'b1, 3 * ticks);
  endtask

  // Holds the line at space for a number of x16 bit times
  task automatic hold_low(input int bits);
    put_bit(1'b0, 16 * bits);
  endtask

  // Returns the line to mark for a number of x16 bit times
  task automatic idle(input int bits);
    put_bit(1'b1, 16 * bits);
  endtask

endmodule

// ==== test/testbench.sv ====
/*
  Self-checking bench for the serial receive channel.
  Assumes the package constants and the remote transmitter model; drives
  the register port by non-blocking assignment after each rising edge.
*/
`timescale 1ns/1ps
module testbench;
  import serial_rx_pkg::*;

  logic        core_clk;
  logic        reset;
  logic        clk_en;
  logic [2:0]  addr;
  logic [11:0] wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        rx_data;
  logic        bit_clk;
  logic        carrier_n;
  logic        int_req;
  int          mismatches;
  int          checks_done;
  int          cycles;
  int          seed;
  logic [7:0]  d [4];
  logic [7:0]  v;
  logic        ev;
  logic        p;

  // Core clock at 50 MHz
  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  serial_rx_channel u_dut (
    .CORE_CLK_I            (core_clk),
    .RESET_I               (reset),
    .CLK_EN_I              (clk_en),
    .ADDR_I                (addr),
    .WDATA_I               (wdata),
    .WR_I                  (wr),
    .RD_I                  (rd),
    .RDATA_O               (rdata),
    .RX_DATA_I             (rx_data),
    .RECEIVE_BIT_CLOCK_I   (bit_clk),
    .CARRIER_DETECT_IN_N_I (carrier_n),
    .INT_O                 (int_req)
  );

  serial_tx_model u_tx (
    .rx_data_o (rx_data),
    .bit_clk_o (bit_clk)
  );

  // Verdict and end of run
  task automatic final_report();
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Cuts a hung run short
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      mismatches = mismatches + 1;
      final_report();
    end
  end

  // Compares one byte and reports a difference
  task automatic check(input string name, input logic [7:0] e, input logic [7:0] g);
    checks_done = checks_done + 1;
    if (g !== e)
    begin
      mismatches = mismatches + 1;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask

  // One-cycle register write
  task automatic reg_wr(input logic [2:0] a, input logic [11:0] dat);
    @(posedge core_clk);
    addr  <= a;
    wdata <= dat;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr    <= 1'b0;
  endtask

  // One-cycle register read, data taken at the edge closing the following cycle
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] dat);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd   <= 1'b0;
    @(posedge core_clk);
    dat = rdata;
  endtask

  // Builds a configuration word with the receiver enabled
  function automatic logic [11:0] cfg(input int n, input logic pen, input logic even,
                                      input logic [11:0] extra);
    logic [11:0] c;
    c = extra;
    c[CFG_RX_ENABLE] = 1'b1;
    c[CFG_PARITY_EN] = pen;
    c[CFG_PARITY_EVEN] = even;
    c[CFG_LEN_LO +: 2] = 2'(n - 5);
    return c;
  endfunction

  // Parity bit that the transmitter should send
  function automatic logic par(input logic [7:0] dat, input int n, input logic even);
    logic x;
    x = 1'b0;
    for (int i = 0; i < n; i++) x = x ^ dat[i];
    return even ? x : ~x;
  endfunction

  // Assembled character: data, then parity, then fill ones
  function automatic logic [7:0] expect_char(input logic [7:0] dat, input int n,
                                             input logic pen, input logic pb);
    logic [7:0] r;
    r = 8'hFF;
    for (int i = 0; i < n; i++) r[i] = dat[i];
    if (pen && n < 8) r[n] = pb;
    return r;
  endfunction

  // Polls until a character is available
  task automatic wait_avail();
    logic [7:0] s;
    int n;
    s = 8'h00;
    n = 0;
    while (s[MS_RX_AVAIL] !== 1'b1 && n < 400)
    begin
      reg_rd(ADDR_MAIN_STATUS, s);
      n++;
    end
    check("rx_avail", 8'h01, {7'h00, s[MS_RX_AVAIL]});
  endtask

  // Reads error status first, then the character
  task automatic rx_char(input logic [7:0] e_err, input logic [7:0] e_dat);
    logic [7:0] r;
    reg_rd(ADDR_ERROR_STATUS, r);
    check("error_status", e_err, r & 8'h70);
    reg_rd(ADDR_DATA, r);
    check("data", e_dat, r);
  endtask

  // Main sequence
  initial
  begin
    reset = 1'b1; clk_en = 1'b1; addr = 3'h0; wdata = 12'h000;
    wr = 1'b0; rd = 1'b0; carrier_n = 1'b0;
    mismatches = 0; checks_done = 0; cycles = 0; seed = 34720;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    reg_rd(ADDR_MAIN_STATUS, v);
    check("main_status", 8'h4C, v & 8'hCD);
    reg_rd(ADDR_ERROR_STATUS, v);
    check("error_status", 8'h00, v & 8'h70);
    reg_rd(3'h7, v);
    check("unmapped", 8'h00, v);
    // A write while the clock enable is low is lost
    clk_en <= 1'b0;
    reg_wr(ADDR_VECTOR, 12'h0F0);
    clk_en <= 1'b1;
    reg_rd(ADDR_VECTOR, v);
    check("vector_frozen", 8'h00, v);
    // Every length with and without parity
    for (int n = 5; n <= 8; n++)
      for (int pe = 0; pe < 2; pe++)
      begin
        d[0] = 8'($random(seed));
        ev = 1'($random(seed));
        p = par(d[0], n, ev);
        reg_wr(ADDR_CONFIG, cfg(n, 1'(pe), ev, 12'h000));
        u_tx.send(d[0], n, 1'(pe), p, 1'b1, 1'b0);
        wait_avail();
        rx_char(8'h00, expect_char(d[0], n, 1'(pe), p));
      end
    // Parity error latches across a good character
    d[0] = 8'($random(seed));
    d[1] = 8'($random(seed));
    reg_wr(ADDR_CONFIG, cfg(7, 1'b1, 1'b1, 12'h000));
    u_tx.send(d[0], 7, 1'b1, ~par(d[0], 7, 1'b1), 1'b1, 1'b0);
    u_tx.send(d[1], 7, 1'b1, par(d[1], 7, 1'b1), 1'b1, 1'b0);
    rx_char(8'h10, expect_char(d[0], 7, 1'b1, ~par(d[0], 7, 1'b1)));
    rx_char(8'h10, expect_char(d[1], 7, 1'b1, par(d[1], 7, 1'b1)));
    reg_wr(ADDR_COMMAND, {9'h000, CMD_ERROR_RESET});
    reg_rd(ADDR_ERROR_STATUS, v);
    check("error_status", 8'h00, v & 8'h70);
    // Four unread characters: the fourth replaces the third
    reg_wr(ADDR_CONFIG, cfg(8, 1'b0, 1'b0, 12'h000));
    for (int i = 0; i < 4; i++)
    begin
      d[i] = 8'($random(seed));
      u_tx.send(d[i], 8, 1'b0, 1'b0, 1'b1, 1'b0);
    end
    rx_char(8'h00, d[0]);
    rx_char(8'h00, d[1]);
    rx_char(8'h20, d[3]);
    reg_rd(ADDR_MAIN_STATUS, v);
    check("rx_avail", 8'h00, v & 8'h01);
    reg_wr(ADDR_COMMAND, {9'h000, CMD_ERROR_RESET});
    // Framing error with status affecting the vector
    reg_wr(ADDR_VECTOR, 12'h000);
    reg_wr(ADDR_CONFIG, cfg(8, 1'b0, 1'b0, 12'hA00));
    d[0] = 8'($random(seed));
    d[1] = 8'($random(seed));
    u_tx.send(d[0], 8, 1'b0, 1'b0, 1'b0, 1'b0);
    wait_avail();
    check("int", 8'h01, {7'h00, int_req});
    reg_rd(ADDR_MODIFIED_VEC, v);
    check("vector", 8'h0E, v & 8'h0E);
    rx_char(8'h40, d[0]);
    u_tx.send(d[1], 8, 1'b0, 1'b0, 1'b1, 1'b0);
    wait_avail();
    reg_rd(ADDR_MODIFIED_VEC, v);
    check("vector", 8'h0C, v & 8'h0E);
    rx_char(8'h00, d[1]);
    // First-character-only mode holds an errored character until error reset
    reg_wr(ADDR_CONFIG, cfg(8, 1'b0, 1'b0, 12'h400));
    d[0] = 8'($random(seed));
    d[1] = 8'($random(seed));
    u_tx.send(d[0], 8, 1'b0, 1'b0, 1'b0, 1'b0);
    u_tx.send(d[1], 8, 1'b0, 1'b0, 1'b1, 1'b0);
    rx_char(8'h40, d[0]);
    rx_char(8'h40, d[0]);
    reg_wr(ADDR_COMMAND, {9'h000, CMD_ERROR_RESET});
    rx_char(8'h40, d[0]);
    reg_rd(ADDR_MAIN_STATUS, v);
    check("rx_avail", 8'h00, v & 8'h01);
    // Receiver disabled: nothing is taken
    reg_wr(ADDR_CONFIG, 12'h000);
    u_tx.send(8'($random(seed)), 8, 1'b0, 1'b0, 1'b1, 1'b0);
    reg_rd(ADDR_MAIN_STATUS, v);
    check("rx_avail", 8'h00, v & 8'h01);
    // x1 clock mode
    d[0] = 8'($random(seed));
    reg_wr(ADDR_CONFIG, cfg(8, 1'b0, 1'b0, 12'h080));
    u_tx.send(d[0], 8, 1'b0, 1'b0, 1'b1, 1'b1);
    wait_avail();
    rx_char(8'h00, d[0]);
    // Carrier lost under auto enables
    reg_wr(ADDR_CONFIG, cfg(8, 1'b0, 1'b0, 12'h102));
    reg_wr(ADDR_COMMAND, {9'h000, CMD_EXT_RESET});
    carrier_n <= 1'b1;
    repeat (30) @(posedge core_clk);
    check("int", 8'h01, {7'h00, int_req});
    reg_rd(ADDR_MAIN_STATUS, v);
    check("carrier", 8'h00, v & 8'h08);
    u_tx.send(8'($random(seed)), 8, 1'b0, 1'b0, 1'b1, 1'b0);
    reg_rd(ADDR_MAIN_STATUS, v);
    check("rx_avail", 8'h00, v & 8'h01);
    carrier_n <= 1'b0;
    reg_wr(ADDR_COMMAND, {9'h000, CMD_EXT_RESET});
    d[0] = 8'($random(seed));
    u_tx.send(d[0], 8, 1'b0, 1'b0, 1'b1, 1'b0);
    wait_avail();
    rx_char(8'h00, d[0]);
    // Break start and end each interrupt
    reg_wr(ADDR_CONFIG, cfg(8, 1'b0, 1'b0, 12'h100));
    reg_wr(ADDR_COMMAND, {9'h000, CMD_EXT_RESET});
    u_tx.hold_low(30);
    check("int", 8'h01, {7'h00, int_req});
    reg_rd(ADDR_MAIN_STATUS, v);
    check("break", 8'h80, v & 8'h80);
    reg_wr(ADDR_COMMAND, {9'h000, CMD_EXT_RESET});
    u_tx.idle(4);
    check("int", 8'h01, {7'h00, int_req});
    reg_rd(ADDR_MAIN_STATUS, v);
    check("break", 8'h00, v & 8'h80);
    final_report();
  end

endmodule
